// [rtl/isee_top.sv]
`timescale 1ns/1ps
module isee_top #(
    parameter int ADDR_W = isee_pkg::MEM_ADDR_W,
    parameter int WR_TIME_NS = isee_pkg::WR_TIME_NS
) (
    input wire logic sys_clk,
    input wire logic nrst,
    input wire logic link_clk,
    input wire logic scl_in,
    input wire logic sda_in,
    output logic sda_out,
    output logic sda_oe,
    input wire logic addr_select_pin_0,
    input wire logic addr_select_pin_1,
    input wire logic addr_select_pin_2,
    output logic write_busy
);
    localparam int HI_BITS = ADDR_W - 8;
    localparam int DEPTH = 1 << ADDR_W;
    localparam int WR_CYCLES = isee_pkg::isee_cycles_floor(WR_TIME_NS);
    localparam logic [31:0] WR_LAST = 32'(WR_CYCLES - 1);

    // ****************************************
    // link domain synchronisers
    // ****************************************
    logic link_rst_n;
    logic [1:0] bus_raw;
    logic [2:0] pins;
    logic done_sync;
    logic done_tgl;
    logic wr_req_tgl;
    isee_pkg::isee_bus_t bus_s;
    isee_pkg::isee_bus_t bus_q;

    isee_sync #(.W(1)) u_rst_sync (.clk(link_clk), .rst_n(1'b1), .d(nrst), .q(link_rst_n));
    isee_sync #(.W(2)) u_bus_sync (.clk(link_clk), .rst_n(link_rst_n), .d({scl_in, sda_in}), .q(bus_raw));
    isee_sync #(.W(3)) u_pin_sync (
        .clk(link_clk),
        .rst_n(link_rst_n),
        .d({addr_select_pin_2, addr_select_pin_1, addr_select_pin_0}),
        .q(pins)
    );
    isee_sync #(.W(1)) u_done_sync (.clk(link_clk), .rst_n(link_rst_n), .d(done_tgl), .q(done_sync));

    assign bus_s = bus_raw;

    // ****************************************
    // bus condition decode
    // ****************************************
    logic scl_rise;
    logic scl_fall;
    logic start_c;
    logic stop_c;

    assign scl_rise = bus_s.scl & ~bus_q.scl;
    assign scl_fall = ~bus_s.scl & bus_q.scl;
    assign start_c = bus_s.scl & bus_q.scl & bus_q.sda & ~bus_s.sda;
    assign stop_c = bus_s.scl & bus_q.scl & ~bus_q.sda & bus_s.sda;

    // ****************************************
    // helpers
    // ****************************************
    function automatic logic addr_ok(isee_pkg::isee_slave_addr_t a, logic [2:0] p);
        logic ok;
        ok = (a.dev_type == isee_pkg::DEV_TYPE);
        for (int i = 0; i < isee_pkg::SEL_BITS; i++) begin
            if (i >= HI_BITS && a.sel[i] != p[i]) begin
                ok = 1'b0;
            end
        end
        return ok;
    endfunction : addr_ok

    function automatic logic [ADDR_W-1:0] word_ptr(logic [2:0] s, logic [7:0] b);
        logic [10:0] w;
        w = {s, b};
        return w[ADDR_W-1:0];
    endfunction : word_ptr

    // ****************************************
    // link state
    // ****************************************
    isee_pkg::isee_state_t state;
    isee_pkg::isee_state_t next_state;
    logic [2:0] cnt, next_cnt;
    logic [7:0] rx_sh, next_rx_sh;
    logic rx_done, next_rx_done;
    logic [7:0] tx_sh, next_tx_sh;
    logic m_ack, next_m_ack;
    logic next_oe;
    logic rw, next_rw;
    logic [2:0] sel, next_sel;
    logic [ADDR_W-1:0] ptr, next_ptr;
    logic pending, next_pending;
    logic link_busy, next_busy;
    logic next_req;
    logic done_seen, next_done_seen;
    logic [isee_pkg::PAGE_BYTES-1:0] mask, next_mask;
    logic buf_we;
    logic commit;
    logic [7:0] rd_byte;
    isee_pkg::isee_slave_addr_t slv;
    logic [7:0] mem [DEPTH];
    logic [7:0] page_buf [isee_pkg::PAGE_BYTES];

    assign rd_byte = mem[ptr];
    assign slv = rx_sh;

    always_comb begin
        next_state = state;
        next_cnt = cnt;
        next_rx_sh = rx_sh;
        next_rx_done = rx_done;
        next_tx_sh = tx_sh;
        next_m_ack = m_ack;
        next_oe = sda_oe;
        next_rw = rw;
        next_sel = sel;
        next_ptr = ptr;
        next_pending = pending;
        next_busy = link_busy;
        next_req = wr_req_tgl;
        next_done_seen = done_seen;
        next_mask = mask;
        buf_we = 1'b0;
        commit = 1'b0;
        if (done_sync != done_seen) begin
            next_done_seen = done_sync;
            next_busy = 1'b0;
            commit = 1'b1;
            next_mask = '0;
        end
        if (start_c) begin
            next_state = isee_pkg::ST_ADDR;
            next_cnt = isee_pkg::BIT_FIRST;
            next_rx_done = 1'b0;
            next_oe = 1'b0;
        end else if (stop_c) begin
            next_state = isee_pkg::ST_IDLE;
            next_oe = 1'b0;
            if (pending) begin
                next_pending = 1'b0;
                next_busy = 1'b1;
                next_req = ~wr_req_tgl;
            end
        end else if (scl_rise) begin
            case (state)
                isee_pkg::ST_ADDR, isee_pkg::ST_WORD, isee_pkg::ST_DATA: begin
                    next_rx_sh = {rx_sh[6:0], bus_s.sda};
                    next_cnt = cnt + 3'h1;
                    next_rx_done = (cnt == isee_pkg::BIT_LAST);
                end
                isee_pkg::ST_TX_ACK: begin
                    next_m_ack = ~bus_s.sda;
                end
                default: begin
                end
            endcase
        end else if (scl_fall) begin
            case (state)
                isee_pkg::ST_ADDR: begin
                    if (rx_done) begin
                        next_rx_done = 1'b0;
                        if (addr_ok(slv, pins) && !link_busy) begin
                            next_state = isee_pkg::ST_ADDR_ACK;
                            next_oe = 1'b1;
                            next_rw = slv.rw;
                            next_sel = slv.sel;
                        end else begin
                            next_state = isee_pkg::ST_IDLE;
                        end
                    end
                end
                isee_pkg::ST_WORD: begin
                    if (rx_done) begin
                        next_rx_done = 1'b0;
                        next_ptr = word_ptr(sel, rx_sh);
                        next_state = isee_pkg::ST_WORD_ACK;
                        next_oe = 1'b1;
                    end
                end
                isee_pkg::ST_DATA: begin
                    if (rx_done) begin
                        next_rx_done = 1'b0;
                        buf_we = 1'b1;
                        next_mask[ptr[3:0]] = 1'b1;
                        next_ptr = {ptr[ADDR_W-1:4], 4'(ptr[3:0] + 4'h1)};
                        next_pending = 1'b1;
                        next_state = isee_pkg::ST_DATA_ACK;
                        next_oe = 1'b1;
                    end
                end
                isee_pkg::ST_ADDR_ACK: begin
                    next_cnt = isee_pkg::BIT_FIRST;
                    if (rw) begin
                        next_tx_sh = rd_byte;
                        next_oe = ~rd_byte[7];
                        next_ptr = ptr + 1'b1;
                        next_state = isee_pkg::ST_TX;
                    end else begin
                        next_oe = 1'b0;
                        next_state = isee_pkg::ST_WORD;
                    end
                end
                isee_pkg::ST_WORD_ACK, isee_pkg::ST_DATA_ACK: begin
                    next_cnt = isee_pkg::BIT_FIRST;
                    next_oe = 1'b0;
                    next_state = isee_pkg::ST_DATA;
                end
                isee_pkg::ST_TX: begin
                    if (cnt == isee_pkg::BIT_LAST) begin
                        next_oe = 1'b0;
                        next_state = isee_pkg::ST_TX_ACK;
                    end else begin
                        next_cnt = cnt + 3'h1;
                        next_tx_sh = {tx_sh[6:0], 1'b0};
                        next_oe = ~tx_sh[6];
                    end
                end
                isee_pkg::ST_TX_ACK: begin
                    next_cnt = isee_pkg::BIT_FIRST;
                    if (m_ack) begin
                        next_tx_sh = rd_byte;
                        next_oe = ~rd_byte[7];
                        next_ptr = ptr + 1'b1;
                        next_state = isee_pkg::ST_TX;
                    end else begin
                        next_oe = 1'b0;
                        next_state = isee_pkg::ST_IDLE;
                    end
                end
                default: begin
                end
            endcase
        end
    end

    always_ff @(posedge link_clk) begin
        if (!link_rst_n) begin
            state <= isee_pkg::ST_IDLE;
            bus_q <= '1;
            cnt <= isee_pkg::BIT_FIRST;
            rx_sh <= '0;
            rx_done <= 1'b0;
            tx_sh <= '0;
            m_ack <= 1'b0;
            sda_oe <= 1'b0;
            sda_out <= 1'b0;
            rw <= 1'b0;
            sel <= '0;
            ptr <= '0;
            pending <= 1'b0;
            link_busy <= 1'b0;
            wr_req_tgl <= 1'b0;
            done_seen <= 1'b0;
            mask <= '0;
        end else begin
            state <= next_state;
            bus_q <= bus_s;
            cnt <= next_cnt;
            rx_sh <= next_rx_sh;
            rx_done <= next_rx_done;
            tx_sh <= next_tx_sh;
            m_ack <= next_m_ack;
            sda_oe <= next_oe;
            sda_out <= 1'b0;
            rw <= next_rw;
            sel <= next_sel;
            ptr <= next_ptr;
            pending <= next_pending;
            link_busy <= next_busy;
            wr_req_tgl <= next_req;
            done_seen <= next_done_seen;
            mask <= next_mask;
        end
    end

    // ****************************************
    // page buffer and array
    // ****************************************
    always_ff @(posedge link_clk) begin
        if (buf_we) begin
            page_buf[ptr[3:0]] <= rx_sh;
        end
    end

    always_ff @(posedge link_clk) begin
        if (!link_rst_n) begin
            for (int i = 0; i < DEPTH; i++) begin
                mem[i] <= isee_pkg::ERASED_BYTE;
            end
        end else if (commit) begin
            for (int i = 0; i < isee_pkg::PAGE_BYTES; i++) begin
                if (mask[i]) begin
                    mem[{ptr[ADDR_W-1:4], 4'(i)}] <= page_buf[i];
                end
            end
        end
    end

    // ****************************************
    // write cycle timer, system domain
    // ****************************************
    logic req_sync;
    logic req_seen, next_req_seen;
    logic next_wbusy;
    logic next_done;
    logic [31:0] wr_cnt, next_wr_cnt;

    isee_sync #(.W(1)) u_req_sync (.clk(sys_clk), .rst_n(nrst), .d(wr_req_tgl), .q(req_sync));

    always_comb begin
        next_req_seen = req_seen;
        next_wbusy = write_busy;
        next_done = done_tgl;
        next_wr_cnt = wr_cnt;
        if (write_busy) begin
            if (wr_cnt == WR_LAST) begin
                next_wbusy = 1'b0;
                next_done = ~done_tgl;
                next_wr_cnt = '0;
            end else begin
                next_wr_cnt = wr_cnt + 32'h1;
            end
        end else if (req_sync != req_seen) begin
            next_req_seen = req_sync;
            next_wbusy = 1'b1;
            next_wr_cnt = '0;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!nrst) begin
            req_seen <= 1'b0;
            write_busy <= 1'b0;
            done_tgl <= 1'b0;
            wr_cnt <= '0;
        end else begin
            req_seen <= next_req_seen;
            write_busy <= next_wbusy;
            done_tgl <= next_done;
            wr_cnt <= next_wr_cnt;
        end
    end

    // ****************************************
    // checks
    // ****************************************
    chk_sda_low_only: assert property (@(posedge link_clk) disable iff (!link_rst_n) sda_out == 1'b0)
        else $error("sda driven high");
    chk_start_to_addr: assert property (@(posedge link_clk) disable iff (!link_rst_n)
        start_c |=> state == isee_pkg::ST_ADDR && !sda_oe)
        else $error("start not decoded");
    chk_stop_to_idle: assert property (@(posedge link_clk) disable iff (!link_rst_n)
        (stop_c && !start_c) |=> state == isee_pkg::ST_IDLE && !sda_oe)
        else $error("stop not decoded");
    chk_stop_launch: assert property (@(posedge link_clk) disable iff (!link_rst_n)
        (stop_c && pending) |=> link_busy && wr_req_tgl != $past(wr_req_tgl))
        else $error("write not launched");
    chk_type_refused: assert property (@(posedge link_clk) disable iff (!link_rst_n)
        (state == isee_pkg::ST_ADDR && scl_fall && rx_done && !start_c && !stop_c
        && rx_sh[7:4] != isee_pkg::DEV_TYPE) |=> state == isee_pkg::ST_IDLE && !sda_oe)
        else $error("foreign address acknowledged");
    chk_busy_nack: assert property (@(posedge link_clk) disable iff (!link_rst_n)
        (state == isee_pkg::ST_ADDR && scl_fall && rx_done && !start_c && !stop_c && link_busy)
        |=> state == isee_pkg::ST_IDLE && !sda_oe)
        else $error("responded while busy");
    chk_ack_drives: assert property (@(posedge link_clk) disable iff (!link_rst_n)
        (state inside {isee_pkg::ST_ADDR_ACK, isee_pkg::ST_WORD_ACK, isee_pkg::ST_DATA_ACK}) |-> sda_oe)
        else $error("ack not driven");
    chk_read_release: assert property (@(posedge link_clk) disable iff (!link_rst_n)
        state == isee_pkg::ST_TX_ACK |-> !sda_oe)
        else $error("sda held in master ack");
    chk_page_fixed: assert property (@(posedge link_clk) disable iff (!link_rst_n)
        (state == isee_pkg::ST_DATA && scl_fall && rx_done && !start_c && !stop_c)
        |=> ptr[ADDR_W-1:4] == $past(ptr[ADDR_W-1:4]) && ptr[3:0] == 4'($past(ptr[3:0]) + 4'h1))
        else $error("page pointer moved");
    chk_oe_on_fall: assert property (@(posedge link_clk) disable iff (!link_rst_n)
        $changed(sda_oe) |-> $past(scl_fall) || $past(start_c) || $past(stop_c))
        else $error("sda changed outside scl fall");
    chk_seq_wrap: assert property (@(posedge link_clk) disable iff (!link_rst_n)
        (state == isee_pkg::ST_TX_ACK && scl_fall && m_ack && !start_c && !stop_c)
        |=> ptr == ADDR_W'($past(ptr) + 1'b1))
        else $error("read pointer not advanced");
    cov_byte_write: cover property (@(posedge link_clk) disable iff (!link_rst_n) stop_c && pending);
    cov_seq_read: cover property (@(posedge link_clk) disable iff (!link_rst_n)
        state == isee_pkg::ST_TX_ACK && scl_fall && m_ack);
    cov_busy_poll: cover property (@(posedge link_clk) disable iff (!link_rst_n)
        state == isee_pkg::ST_ADDR && scl_fall && rx_done && link_busy);
    cov_commit: cover property (@(posedge link_clk) disable iff (!link_rst_n) commit);
endmodule : isee_top

// [rtl/isee_pkg.sv]
// Summary of operation
// - sda change while scl high is start/stop
// - start precedes commands; idle until start
// - stop ends command; launches write or standby
// - respond only to device type 1010
// - select bits match pins or are address
// - address lsb: one reads, zero writes
// - acknowledge low in ninth clock on receive
// - read: release ninth clock, continue while acked
// - byte write: address, word, data, stop
// - busy writing: sda released, no response
// - page write: sixteen bytes, low nibble increments
// - more than sixteen bytes wrap the page
// - polling: nack while busy, ack after
// - read without word address uses pointer
// - dummy write then repeated start reads
// - sequential read wraps at memory end
// - sda only pulled low, never driven high
// - reset mode while reset, standby after
// - memory starts erased, all bytes ff
// - sample on scl rise, change on fall
package isee_pkg;
    // ****************************************
    // timing
    // ****************************************
    localparam int SYS_CLK_PERIOD_NS = 4;
    localparam int WR_TIME_NS = 5000000;

    // ****************************************
    // memory and address layout
    // ****************************************
    localparam int MEM_ADDR_W = 8;
    localparam int PAGE_BYTES = 16;
    localparam int SEL_BITS = 3;
    localparam logic [3:0] DEV_TYPE = 4'hA;
    localparam logic [7:0] ERASED_BYTE = 8'hFF;
    localparam logic [2:0] BIT_LAST = 3'h7;
    localparam logic [2:0] BIT_FIRST = 3'h0;

    // ****************************************
    // types
    // ****************************************
    typedef enum logic [3:0] {
        ST_IDLE = 4'h0,
        ST_ADDR = 4'h1,
        ST_ADDR_ACK = 4'h2,
        ST_WORD = 4'h3,
        ST_WORD_ACK = 4'h4,
        ST_DATA = 4'h5,
        ST_DATA_ACK = 4'h6,
        ST_TX = 4'h7,
        ST_TX_ACK = 4'h8
    } isee_state_t;

    typedef struct packed {
        logic scl;
        logic sda;
    } isee_bus_t;

    typedef struct packed {
        logic [3:0] dev_type;
        logic [2:0] sel;
        logic rw;
    } isee_slave_addr_t;

    function automatic int isee_cycles_floor(int ns);
        int c;
        c = ns / SYS_CLK_PERIOD_NS;
        return (c < 1) ? 1 : c;
    endfunction : isee_cycles_floor
endpackage : isee_pkg

// [rtl/isee_sync.sv]
`timescale 1ns/1ps
module isee_sync #(
    parameter int W = 1
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic [W-1:0] d,
    output logic [W-1:0] q
);
    logic [W-1:0] stage1;
    logic [W-1:0] next_stage1;
    logic [W-1:0] next_q;

    always_comb begin
        next_stage1 = d;
        next_q = stage1;
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            stage1 <= '0;
            q <= '0;
        end else begin
            stage1 <= next_stage1;
            q <= next_q;
        end
    end
endmodule : isee_sync

// [testbench/isee_master.sv]
`timescale 1ns/1ps
module isee_master #(
    parameter int QTR = 32
) (
    input wire logic clk,
    input wire logic sda,
    output logic scl,
    output logic sda_drv
);
    // ****************************************
    // bus master model, open drain on sda
    // ****************************************
    initial begin
        scl = 1'b1;
        sda_drv = 1'b1;
    end

    task automatic hold();
        repeat (QTR) @(negedge clk);
    endtask : hold

    // start from idle bus or as repeated start
    task automatic start();
        sda_drv = 1'b1;
        hold();
        scl = 1'b1;
        hold();
        sda_drv = 1'b0;
        hold();
        scl = 1'b0;
        hold();
    endtask : start

    task automatic stop();
        sda_drv = 1'b0;
        hold();
        scl = 1'b1;
        hold();
        sda_drv = 1'b1;
        hold();
    endtask : stop

    // sda changes only while scl low
    task automatic xfer_bit(input logic b, output logic r);
        sda_drv = b;
        hold();
        scl = 1'b1;
        hold();
        r = sda;
        hold();
        scl = 1'b0;
        hold();
    endtask : xfer_bit

    task automatic wr_byte(input logic [7:0] d, output logic ack);
        logic r;
        for (int i = 7; i >= 0; i--) begin
            xfer_bit(d[i], r);
        end
        xfer_bit(1'b1, r);
        ack = ~r;
    endtask : wr_byte

    // master acks to continue, withholds ack to end the read
    task automatic rd_byte(input logic ack, output logic [7:0] d);
        logic r;
        for (int i = 7; i >= 0; i--) begin
            xfer_bit(1'b1, d[i]);
        end
        xfer_bit(~ack, r);
    endtask : rd_byte
endmodule : isee_master

// [testbench/isee_bench.sv]
`timescale 1ns/1ps
module isee_bench;
    localparam logic [2:0] PINS = 3'h5;
    localparam logic [7:0] WR_ADDR = {isee_pkg::DEV_TYPE, PINS, 1'b0};
    localparam logic [7:0] RD_ADDR = {isee_pkg::DEV_TYPE, PINS, 1'b1};
    logic sys_clk;
    logic link_clk;
    logic nrst;
    logic scl;
    logic sda_drv;
    logic sda;
    logic sda_out;
    logic sda_oe;
    logic write_busy;
    int n_mismatch;
    int n_compared;
    logic [7:0] exp_page [16];

    // wire level: pull-up unless a party pulls low
    assign sda = sda_drv & ~sda_oe;

    initial begin
        sys_clk = 1'b0;
        forever #2 sys_clk = ~sys_clk;
    end

    initial begin
        link_clk = 1'b0;
        #7;
        forever #15 link_clk = ~link_clk;
    end

    isee_master mst (
        .clk(sys_clk),
        .sda(sda),
        .scl(scl),
        .sda_drv(sda_drv)
    );

    isee_top #(
        .ADDR_W(8),
        .WR_TIME_NS(20000)
    ) dut (
        .sys_clk(sys_clk),
        .nrst(nrst),
        .link_clk(link_clk),
        .scl_in(scl),
        .sda_in(sda),
        .sda_out(sda_out),
        .sda_oe(sda_oe),
        .addr_select_pin_0(PINS[0]),
        .addr_select_pin_1(PINS[1]),
        .addr_select_pin_2(PINS[2]),
        .write_busy(write_busy)
    );

    // ****************************************
    // checking and closing
    // ****************************************
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        n_compared++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : check

    task automatic conclude();
        $display("comparisons %0d mismatches %0d", n_compared, n_mismatch);
        if (n_mismatch == 0 && n_compared > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask : conclude

    // one byte to the slave, ack compared
    task automatic send(input logic [7:0] d, input logic exp_ack);
        logic ack;
        mst.wr_byte(d, ack);
        check({7'h00, ack}, {7'h00, exp_ack});
        if (ack === 1'b1) begin
            check({7'h00, sda_out}, 8'h00);
        end
    endtask : send

    task automatic sel_read(input logic [7:0] a);
        mst.start();
        send(WR_ADDR, 1'b1);
        send(a, 1'b1);
        mst.start();
        send(RD_ADDR, 1'b1);
    endtask : sel_read

    // poll with write addresses until the write cycle ends
    task automatic wait_write();
        logic ack;
        for (int i = 0; i < 20; i++) begin
            mst.start();
            mst.wr_byte(WR_ADDR, ack);
            mst.stop();
            if (i == 0) begin
                check({7'h00, ack}, 8'h00);
                check({7'h00, write_busy}, 8'h01);
            end
            if (ack === 1'b1) begin
                return;
            end
        end
        n_mismatch++;
        conclude();
    endtask : wait_write

    // ****************************************
    // scenarios
    // ****************************************
    task automatic t_erased();
        logic [7:0] d;
        mst.start();
        send(RD_ADDR, 1'b1);
        mst.rd_byte(1'b0, d);
        mst.stop();
        check(d, isee_pkg::ERASED_BYTE);
        $display("test erased done");
    endtask : t_erased

    task automatic t_byte_write();
        logic [7:0] d;
        mst.start();
        send(WR_ADDR, 1'b1);
        send(8'h00, 1'b1);
        send(8'h3C, 1'b1);
        mst.stop();
        wait_write();
        sel_read(8'h00);
        mst.rd_byte(1'b0, d);
        mst.stop();
        check(d, 8'h3C);
        $display("test byte_write done");
    endtask : t_byte_write

    task automatic t_page_wrap();
        logic [7:0] d;
        mst.start();
        send(WR_ADDR, 1'b1);
        send(8'h1E, 1'b1);
        for (int i = 0; i < 18; i++) begin
            send(8'h40 + 8'(i), 1'b1);
            exp_page[(14 + i) % 16] = 8'h40 + 8'(i);
        end
        mst.stop();
        wait_write();
        sel_read(8'h10);
        for (int i = 0; i < 16; i++) begin
            mst.rd_byte(i != 15, d);
            check(d, exp_page[i]);
        end
        mst.stop();
        $display("test page_wrap done");
    endtask : t_page_wrap

    task automatic t_read_wrap();
        logic [7:0] d;
        sel_read(8'hFF);
        mst.rd_byte(1'b1, d);
        check(d, isee_pkg::ERASED_BYTE);
        mst.rd_byte(1'b0, d);
        check(d, 8'h3C);
        mst.stop();
        $display("test read_wrap done");
    endtask : t_read_wrap

    task automatic t_refuse();
        mst.start();
        send({4'hB, PINS, 1'b0}, 1'b0);
        mst.stop();
        mst.start();
        send({isee_pkg::DEV_TYPE, 3'h2, 1'b1}, 1'b0);
        mst.stop();
        mst.start();
        send({isee_pkg::DEV_TYPE, 3'h4, 1'b0}, 1'b0);
        mst.stop();
        mst.start();
        send(WR_ADDR, 1'b1);
        mst.stop();
        $display("test refuse done");
    endtask : t_refuse

    initial begin
        n_mismatch = 0;
        n_compared = 0;
        nrst = 1'b0;
        repeat (5) @(negedge link_clk);
        @(negedge sys_clk);
        check({6'h00, sda_oe, write_busy}, 8'h00);
        nrst = 1'b1;
        repeat (60) @(negedge sys_clk);
        check({6'h00, sda_oe, write_busy}, 8'h00);
        t_erased();
        t_byte_write();
        t_page_wrap();
        t_read_wrap();
        t_refuse();
        conclude();
    end
endmodule : isee_bench
